// File: core/afx_fifo.sv
// buffer between the user's write stream and the device write strobe
// assumes one clock; ready and valid come straight from flops
`timescale 1ns/1ps
module afx_fifo
    import afx_pkg::*;
#(
    parameter int W     = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic  clk,    // system clock
    input  wire logic  rst,    // async reset, active high
    afx_stream_if.snk  fill,   // words in
    afx_stream_if.src  drain   // words out
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_r, wptr_nxt;
    logic [AW-1:0] rptr_r, rptr_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          ready_r, ready_nxt;
    logic          valid_r, valid_nxt;
    logic          push;
    logic          pop;

    always_comb begin
        push      = fill.valid && ready_r;
        pop       = drain.ready && valid_r;
        wptr_nxt  = push ? AW'(wptr_r + 1'b1) : wptr_r;
        rptr_nxt  = pop ? AW'(rptr_r + 1'b1) : rptr_r;
        cnt_nxt   = (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop));
        ready_nxt = cnt_nxt != (AW+1)'(DEPTH);
        valid_nxt = cnt_nxt != '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            cnt_r   <= '0;
            ready_r <= 1'b1;
            valid_r <= 1'b0;
        end else begin
            wptr_r  <= wptr_nxt;
            rptr_r  <= rptr_nxt;
            cnt_r   <= cnt_nxt;
            ready_r <= ready_nxt;
            valid_r <= valid_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= fill.data;
        end
    end

    assign fill.ready  = ready_r;
    assign drain.valid = valid_r;
    assign drain.data  = mem[rptr_r];
endmodule

// File: core/afx_host.sv
// host controller that drives one or more strobe-driven fifo devices by their pins
// assumes device pins are asynchronous; depth_mode is a static strap from local logic
`timescale 1ns/1ps
module afx_host
    import afx_pkg::*;
#(
    parameter int NDEV  = 1,
    parameter int DW    = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic            clk,          // system clock
    input  wire logic            rst,          // async reset, active high
    input  wire logic            depth_mode,   // 1: devices chained in depth
    input  wire logic            clr_req,      // pulse: clear all devices
    input  wire logic            rewind_req,   // pulse: rewind, single/width only
    input  wire logic            rd_req,       // level: fetch a word when one is there
    input  wire logic            in_valid,     // write stream valid
    input  wire logic [DW-1:0]   in_data,      // write stream word
    output logic                 in_ready,     // write stream ready
    output logic                 rd_valid,     // pulse: rd_data holds a word
    output logic [DW-1:0]        rd_data,      // word read from the device
    output logic                 half_full,    // device reports half full; always low in depth mode
    output logic                 busy,         // a strobe sequence is running
    output logic                 wr_n,         // device write strobe
    output logic [DW-1:0]        dev_din,      // device data in
    output logic                 rd_n,         // device read strobe
    output logic                 clear_n,      // device reset
    output logic [NDEV-1:0]      fl_rt_n,      // first-load / rewind per device
    input  wire logic [DW-1:0]   out_bus,      // device data out
    input  wire logic [NDEV-1:0] full_n,       // device full flags
    input  wire logic [NDEV-1:0] empty_n,      // device empty flags
    input  wire logic            half_n        // half flag of device 0
);
    afx_stream_if #(.W(DW)) fill_if ();
    afx_stream_if #(.W(DW)) drain_if ();

    assign fill_if.valid = in_valid;
    assign fill_if.data  = in_data;
    assign in_ready      = fill_if.ready;

    afx_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .fill  (fill_if),
        .drain (drain_if)
    );

    logic [NDEV-1:0] full_m_r, full_s_r;
    logic [NDEV-1:0] empty_m_r, empty_s_r;
    logic [DW-1:0]   q_m_r, q_s_r;
    logic            half_m_r, half_s_r;

    for (genvar i = 0; i < NDEV; i++) begin : g_sync
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                full_m_r[i]  <= 1'b1;
                full_s_r[i]  <= 1'b1;
                empty_m_r[i] <= 1'b0;
                empty_s_r[i] <= 1'b0;
            end else begin
                full_m_r[i]  <= full_n[i];
                full_s_r[i]  <= full_m_r[i];
                empty_m_r[i] <= empty_n[i];
                empty_s_r[i] <= empty_m_r[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_m_r    <= '0;
            q_s_r    <= '0;
            half_m_r <= 1'b1;
            half_s_r <= 1'b1;
        end else begin
            q_m_r    <= out_bus;
            q_s_r    <= q_m_r;
            half_m_r <= half_n;
            half_s_r <= half_m_r;
        end
    end

    // first device loads low, the rest high; a cast avoids a zero-width replication when NDEV is 1
    localparam logic [NDEV-1:0] FL_FIRST = ~NDEV'(1);

    logic can_write;
    logic can_read;

    // chained devices: composites from all flags; otherwise device 0 alone
    always_comb begin
        can_write = depth_mode ? |full_s_r : full_s_r[0];
        can_read  = depth_mode ? |empty_s_r : empty_s_r[0];
    end

    afx_state_t      state_r, state_nxt;
    logic [3:0]      cnt_r, cnt_nxt;
    logic            wr_n_r, wr_n_nxt;
    logic            rd_n_r, rd_n_nxt;
    logic            clear_n_r, clear_n_nxt;
    logic            rt_n_r, rt_n_nxt;
    logic [NDEV-1:0] fl_rt_n_r, fl_rt_n_nxt;
    logic [DW-1:0]   din_r, din_nxt;
    logic [DW-1:0]   rd_data_r, rd_data_nxt;
    logic            rd_valid_r, rd_valid_nxt;
    logic            half_r, half_nxt;
    logic            busy_r, busy_nxt;
    logic            pop;
    logic            cnt_done;

    always_comb begin
        state_nxt    = state_r;
        cnt_done     = cnt_r == 4'h0;
        cnt_nxt      = cnt_done ? 4'h0 : 4'(cnt_r - 4'h1);
        wr_n_nxt     = wr_n_r;
        rd_n_nxt     = rd_n_r;
        clear_n_nxt  = clear_n_r;
        rt_n_nxt     = rt_n_r;
        din_nxt      = din_r;
        rd_data_nxt  = rd_data_r;
        rd_valid_nxt = 1'b0;
        pop          = 1'b0;
        unique case (state_r)
            ST_CLR: begin
                if (cnt_done) begin
                    clear_n_nxt = 1'b1;
                    state_nxt   = ST_CLR_REC;
                    cnt_nxt     = HI_LD;
                end
            end
            ST_CLR_REC, ST_WR_HI, ST_RD_HI, ST_RT_HI: begin
                if (cnt_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (clr_req) begin
                    clear_n_nxt = 1'b0;
                    state_nxt   = ST_CLR;
                    cnt_nxt     = CLR_LO_LD;
                end else if (rewind_req && !depth_mode) begin
                    rt_n_nxt  = 1'b0;
                    state_nxt = ST_RT_LO;
                    cnt_nxt   = RT_LO_LD;
                end else if (rd_req && can_read) begin
                    rd_n_nxt  = 1'b0;
                    state_nxt = ST_RD_LO;
                    cnt_nxt   = RD_LO_LD;
                end else if (drain_if.valid && can_write) begin
                    pop       = 1'b1;
                    din_nxt   = drain_if.data;
                    wr_n_nxt  = 1'b0;
                    state_nxt = ST_WR_LO;
                    cnt_nxt   = WR_LO_LD;
                end
            end
            ST_WR_LO: begin
                if (cnt_done) begin
                    wr_n_nxt  = 1'b1;
                    state_nxt = ST_WR_HI;
                    cnt_nxt   = HI_LD;
                end
            end
            ST_RD_LO: begin
                if (cnt_done) begin
                    rd_n_nxt     = 1'b1;
                    rd_data_nxt  = q_s_r;
                    rd_valid_nxt = 1'b1;
                    state_nxt    = ST_RD_HI;
                    cnt_nxt      = HI_LD;
                end
            end
            ST_RT_LO: begin
                if (cnt_done) begin
                    rt_n_nxt  = 1'b1;
                    state_nxt = ST_RT_HI;
                    cnt_nxt   = HI_LD;
                end
            end
        endcase
        // first device load low, the rest high; rewind line in single/width mode
        fl_rt_n_nxt = depth_mode ? FL_FIRST : {NDEV{rt_n_nxt}};
        half_nxt    = !depth_mode && !half_s_r;
        busy_nxt    = state_nxt != ST_IDLE;
    end

    assign drain_if.ready = pop;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_CLR;
            cnt_r      <= CLR_LO_LD;
            wr_n_r     <= 1'b1;
            rd_n_r     <= 1'b1;
            clear_n_r  <= 1'b0;
            rt_n_r     <= 1'b1;
            fl_rt_n_r  <= '1;
            din_r      <= '0;
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
            half_r     <= 1'b0;
            busy_r     <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            wr_n_r     <= wr_n_nxt;
            rd_n_r     <= rd_n_nxt;
            clear_n_r  <= clear_n_nxt;
            rt_n_r     <= rt_n_nxt;
            fl_rt_n_r  <= fl_rt_n_nxt;
            din_r      <= din_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            half_r     <= half_nxt;
            busy_r     <= busy_nxt;
        end
    end

    assign wr_n      = wr_n_r;
    assign rd_n      = rd_n_r;
    assign clear_n   = clear_n_r;
    assign fl_rt_n   = fl_rt_n_r;
    assign dev_din   = din_r;
    assign rd_data   = rd_data_r;
    assign rd_valid  = rd_valid_r;
    assign half_full = half_r;
    assign busy      = busy_r;

    sequence wr_low_s;
        !wr_n_r [*4];
    endsequence

    sequence wr_high_s;
        wr_n_r [*6];
    endsequence

    write_pulse_a: assert property (@(posedge clk) disable iff (rst)
        $fell(wr_n_r) |-> wr_low_s ##1 wr_high_s)
        else $error("write strobe low or high time wrong");

    write_when_room_a: assert property (@(posedge clk) disable iff (rst)
        $fell(wr_n_r) |-> $past(can_write))
        else $error("write strobe fell while device full");

    read_when_data_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rd_n_r) |-> $past(can_read) ##1 !rd_n_r [*6])
        else $error("read strobe fell on empty device or too short");

    read_word_a: assert property (@(posedge clk) disable iff (rst)
        rd_valid_r |-> rd_n_r && $past(!rd_n_r) && rd_data_r == $past(q_s_r))
        else $error("read word not taken at strobe release");

    data_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wr_n_r && $past(!wr_n_r) |-> $stable(din_r))
        else $error("write data moved under low strobe");

    first_load_a: assert property (@(posedge clk) disable iff (rst)
        depth_mode && $past(depth_mode) && !$past(rst) |-> fl_rt_n_r == FL_FIRST)
        else $error("first-load pattern wrong in depth mode");

    no_half_depth_a: assert property (@(posedge clk) disable iff (rst)
        depth_mode && $past(depth_mode) |-> !half_r && rt_n_r)
        else $error("half or rewind active in depth mode");

    composite_full_a: assert property (@(posedge clk) disable iff (rst)
        depth_mode && full_s_r != '0 |-> can_write)
        else $error("composite full flag wrong");
endmodule

// File: core/afx_pkg.sv
// constants for the host that drives an asynchronous strobe-driven fifo device
// assumes a 125 MHz clock and device strobe timing of the slower speed grade
// Notes on behaviour
// - width mode: control inputs common, flags from one device, outputs never joined.
// - depth mode: first-load low on first device only, high on all others.
// - depth mode: each chain output wired to chain input of the next device.
// - depth mode: combine all full flags, and all empty flags, into composites.
// - writer watches full of device written, reader watches empty of device read.
// - writer toggles write strobe only while full is not asserted.
package afx_pkg;
    localparam int CLK_PS      = 8000;
    localparam int STROBE_NS   = 30;
    localparam int RECOVER_NS  = 10;
    localparam int ACCESS_NS   = 30;
    localparam int FLAG_NS     = 30;
    localparam int CLEAR_NS    = 30;
    localparam int SYNC_STAGES = 2;
    localparam int DEV_WORDS   = 4096;

    localparam int STROBE_CYC  = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int ACCESS_CYC  = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FLAG_CYC    = (FLAG_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CLEAR_CYC   = (CLEAR_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // read low long enough for access plus the data synchroniser
    localparam int RD_LO_INT = (ACCESS_CYC + SYNC_STAGES + 1 > STROBE_CYC) ?
                               ACCESS_CYC + SYNC_STAGES + 1 : STROBE_CYC;
    // high time covers recovery and the flags settling through the synchroniser
    localparam int HI_INT    = (FLAG_CYC + SYNC_STAGES > RECOVER_CYC) ?
                               FLAG_CYC + SYNC_STAGES : RECOVER_CYC;

    localparam logic [3:0] WR_LO_LD  = 4'(STROBE_CYC - 1);
    localparam logic [3:0] RD_LO_LD  = 4'(RD_LO_INT - 1);
    localparam logic [3:0] RT_LO_LD  = 4'(STROBE_CYC - 1);
    localparam logic [3:0] HI_LD     = 4'(HI_INT - 1);
    localparam logic [3:0] CLR_LO_LD = 4'(CLEAR_CYC - 1);

    localparam int FIFO_DEPTH = 32;
    localparam int DATA_W     = 9;

    typedef enum logic [3:0] {
        ST_CLR     = 4'h0,
        ST_CLR_REC = 4'h1,
        ST_IDLE    = 4'h2,
        ST_WR_LO   = 4'h3,
        ST_WR_HI   = 4'h4,
        ST_RD_LO   = 4'h5,
        ST_RD_HI   = 4'h6,
        ST_RT_LO   = 4'h7,
        ST_RT_HI   = 4'h8
    } afx_state_t;
endpackage

// File: core/afx_stream_if.sv
// valid/ready word stream between the host's own modules
// assumes source and sink share one clock
`timescale 1ns/1ps
interface afx_stream_if #(parameter int W = 9);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: testbench/afx_dev_model.sv
// behavioural model of one strobe-driven fifo device, single or width mode
// assumes the host drives strobes from a 125 MHz clock; slow stretches flag delays
`timescale 1ns/1ps
module afx_dev_model
    import afx_pkg::*;
#(
    parameter int WORDS = DEV_WORDS
) (
    input  wire logic              wr_n,     // write strobe
    input  wire logic              rd_n,     // read strobe
    input  wire logic              clear_n,  // device reset
    input  wire logic              rt_n,     // rewind
    input  wire logic              xi_n,     // chain in, low for single mode
    input  wire logic              slow,     // late flag updates
    input  wire logic [DATA_W-1:0] din,      // data in
    output logic      [DATA_W-1:0] q,        // data out
    output logic                   full_n,   // full flag
    output logic                   empty_n,  // empty flag
    output logic                   half_n    // half flag on the chain-out pin
);
    logic [DATA_W-1:0] mem [WORDS];
    int                wp;
    int                rp;
    int                used;
    int                wcnt;
    int                lag;
    bit                wr_ok;
    bit                rd_ok;

    always_comb lag = slow ? 20 : 1;
    initial begin
        q       = '0;
        full_n  = 1'b1;
        empty_n = 1'b0;
        half_n  = 1'b1;
        wcnt    = 0;
    end

    always @(negedge clear_n) begin
        wp = 0;
        rp = 0;
        used = 0;
        wr_ok = 0;
        rd_ok = 0;
        empty_n <= #1 1'b0;
        full_n  <= #1 1'b1;
        half_n  <= #1 1'b1;
    end

    always @(negedge wr_n) begin
        wr_ok = clear_n && full_n;
        if (wr_ok) begin
            used++;
            if (used == WORDS) full_n <= #(lag) 1'b0;
            if (used > WORDS / 2 && !xi_n) half_n <= #(lag) 1'b0;
        end
    end

    always @(posedge wr_n) begin
        if (wr_ok) begin
            mem[wp] = din;
            wp = (wp + 1) % WORDS;
            wcnt++;
            empty_n <= #(lag) 1'b1;
        end
        wr_ok = 0;
    end

    always @(negedge rd_n) begin
        rd_ok = clear_n && empty_n;
        if (rd_ok) begin
            q = mem[rp];
            rp = (rp + 1) % WORDS;
            used--;
            if (used == 0) empty_n <= #(lag) 1'b0;
        end
    end

    // released bus shows the inverse so a stale sample never matches
    always @(posedge rd_n) begin
        q = ~q;
        if (rd_ok) begin
            full_n <= #(lag) 1'b1;
            if (used <= WORDS / 2) half_n <= #(lag) 1'b1;
        end
        rd_ok = 0;
    end

    // rewind assumes the write pointer has not wrapped since clear
    always @(negedge rt_n) begin
        if (clear_n && !xi_n) begin
            rp = 0;
            used = wp;
            empty_n <= #(lag) (wp != 0);
            half_n  <= #(lag) !(used > WORDS / 2);
        end
    end
endmodule

// File: testbench/afx_host_tb.sv
// self-checking bench for the fifo device host, one device in single mode
// assumes the device model above with a shortened capacity
`timescale 1ns/1ps
module afx_host_tb;
    import afx_pkg::*;
    localparam int WORDS = 64;
    logic              clk;
    logic              rst;
    logic              clr_req;
    logic              rewind_req;
    logic              rd_req;
    logic              in_valid;
    logic              depth_mode;
    logic              slow;
    logic              in_ready;
    logic              rd_valid;
    logic              half_full;
    logic              busy;
    logic              wr_n;
    logic              rd_n;
    logic              clear_n;
    logic              half_n;
    logic [0:0]        fl_rt_n;
    logic [0:0]        full_n;
    logic [0:0]        empty_n;
    logic [DATA_W-1:0] in_data;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] dev_din;
    logic [DATA_W-1:0] out_bus;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] sent[$];
    int                bad_count;
    int                checks;
    int                nread;
    int                refused;
    int                lows;
    int                n0;
    int                k;

    afx_host #(.NDEV(1)) i_afx_host (.clk(clk), .rst(rst), .depth_mode(depth_mode), .clr_req(clr_req),
        .rewind_req(rewind_req), .rd_req(rd_req), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .rd_valid(rd_valid), .rd_data(rd_data), .half_full(half_full),
        .busy(busy), .wr_n(wr_n), .dev_din(dev_din), .rd_n(rd_n), .clear_n(clear_n),
        .fl_rt_n(fl_rt_n), .out_bus(out_bus), .full_n(full_n), .empty_n(empty_n), .half_n(half_n));

    afx_dev_model #(.WORDS(WORDS)) i_afx_dev_model (.wr_n(wr_n), .rd_n(rd_n), .clear_n(clear_n),
        .rt_n(fl_rt_n[0]), .xi_n(1'b0), .slow(slow), .din(dev_din), .q(out_bus),
        .full_n(full_n[0]), .empty_n(empty_n[0]), .half_n(half_n));

    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("mismatch t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic chk_bit(input logic got, input logic want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("mismatch t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // back-to-back words, valid held high across the whole burst
    task automatic burst(input int n);
        logic [DATA_W-1:0] w;
        in_valid <= 1'b1;
        for (int i = 0; i < n; i++) begin
            w = DATA_W'($urandom);
            in_data <= w;
            exp_q.push_back(w);
            sent.push_back(w);
            @(posedge clk);
            while (in_ready !== 1'b1) begin
                refused++;
                @(posedge clk);
            end
        end
        in_valid <= 1'b0;
    endtask

    task automatic wait_writes(input int target);
        for (k = 0; k < 3000 && i_afx_dev_model.wcnt < target; k++) @(posedge clk);
        repeat (20) @(posedge clk);
        chk_bit(i_afx_dev_model.wcnt >= target, 1'b1);
    endtask

    task automatic drain();
        rd_req <= 1'b1;
        for (k = 0; k < 4000 && exp_q.size() > 0; k++) @(posedge clk);
        repeat (60) @(posedge clk);
        rd_req <= 1'b0;
        chk_word(DATA_W'(exp_q.size()), '0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            nread++;
            if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
            else chk_word(rd_data, exp_q.pop_front());
        end
    end

    initial begin
        #(20000 * 8);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        clr_req = 1'b0;
        rewind_req = 1'b0;
        rd_req = 1'b0;
        in_valid = 1'b0;
        depth_mode = 1'b0;
        in_data = '0;
        slow = 1'b0;
        bad_count = 0;
        checks = 0;
        nread = 0;
        refused = 0;
        lows = 0;
        void'($urandom(24));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        chk_bit(half_full, 1'b0);
        burst(40);
        chk_bit(refused > 0, 1'b1);
        wait_writes(40);
        chk_bit(half_full, 1'b1);
        rd_req <= 1'b1;
        wait (nread == 10);
        rd_req <= 1'b0;
        repeat (30) @(posedge clk);
        rewind_req <= 1'b1;
        @(posedge clk);
        rewind_req <= 1'b0;
        exp_q = sent;
        repeat (20) @(posedge clk);
        drain();
        chk_bit(half_full, 1'b0);
        // fill past capacity with late flags; the spare words wait in the buffer
        slow <= 1'b1;
        burst(WORDS + 6);
        wait_writes(40 + WORDS);
        for (k = 0; k < 200; k++) begin
            @(posedge clk);
            if (wr_n === 1'b0) lows++;
        end
        chk_bit(lows == 0, 1'b1);
        chk_bit(busy, 1'b0);
        chk_bit(half_full, 1'b1);
        drain();
        slow <= 1'b0;
        burst(5);
        wait_writes(46 + WORDS + 5);
        clr_req <= 1'b1;
        @(posedge clk);
        clr_req <= 1'b0;
        exp_q.delete();
        n0 = nread;
        repeat (40) @(posedge clk);
        rd_req <= 1'b1;
        repeat (200) @(posedge clk);
        rd_req <= 1'b0;
        chk_bit(nread == n0, 1'b1);
        chk_bit(half_full, 1'b0);
        // depth strap: first-load pattern out, rewind request ignored
        depth_mode <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit(fl_rt_n[0], 1'b0);
        rewind_req <= 1'b1;
        @(posedge clk);
        rewind_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk_bit(busy, 1'b0);
        chk_bit(half_full, 1'b0);
        tally_and_finish();
    end
endmodule
